// ### verilog/cfi_id_bank.sv
// Identification and cache selection bank of the system control coprocessor.
// Assumes requests come from core logic on mclk and hold for one cycle each.
module cfi_id_bank
  import cfi_pkg::*;
(
  input  wire logic        mclk,              // Core clock
  input  wire logic        reset,             // Asynchronous reset, high
  input  wire logic        cp_valid,          // Coprocessor move request
  input  wire logic        cp_write,          // 1 write to bank, 0 read
  input  wire logic [2:0]  cp_opc1,           // First opcode
  input  wire logic [3:0]  cp_crn,            // Primary register
  input  wire logic [3:0]  cp_crm,            // Secondary register
  input  wire logic [2:0]  cp_opc2,           // Second opcode
  input  wire logic [31:0] cp_wdata,          // Write data
  input  wire logic        cp_priv,           // Requester is privileged
  input  wire logic        cp_ns,             // Requester is non-secure
  input  wire logic        sec_wr_disable,    // Blocks secure control writes
  input  wire logic        nmfi_pin,          // Fast interrupt mask strap
  output logic      [31:0] cp_rdata,          // Read data
  output logic             cp_done,           // Access completed
  output logic             cp_undef,          // Undefined instruction
  output logic             cp_unclaimed,      // Not a register of this bank
  output logic             mmu_enable,        // Translation on
  output logic             dcache_enable,     // Data caching on
  output logic             flow_pred_enable,  // Flow prediction on
  output logic             icache_enable,     // Instruction caching on
  output logic             icache_selected    // Select picks instr cache
);
  import cfi_pkg::*;

  // ***************************************************
  // Decode and banked storage
  // ***************************************************

  cfi_dec_if dec_bus ();

  // Coordinates go to the decoder straight from the request
  assign dec_bus.opc1 = cp_opc1;
  assign dec_bus.crn  = cp_crn;
  assign dec_bus.crm  = cp_crm;
  assign dec_bus.opc2 = cp_opc2;

  cfi_decode u_decode (
    .dec (dec_bus.dec)
  );

  logic        csel_wr;
  logic        csel_q;
  logic        sctl_wr;
  logic [3:0]  sctl_wdata;
  logic [3:0]  sctl_q;
  logic [3:0]  sctl_ns_q;
  logic        rd_ns;

  // Cache select is banked per security state
  cfi_bank_reg #(
    .W   (1),
    .RST (CSEL_RST)
  ) u_csel (
    .mclk  (mclk),
    .reset (reset),
    .wr_en (csel_wr),
    .wr_ns (cp_ns),
    .wdata (cp_wdata[CSEL_IND_POS]),
    .rd_ns (rd_ns),
    .q     (csel_q),
    .q_sec ()
  );

  // Banked enables of the control word: M, C, Z, I
  cfi_bank_reg #(
    .W   (4),
    .RST (SCTL_BANK_RST)
  ) u_sctl (
    .mclk  (mclk),
    .reset (reset),
    .wr_en (sctl_wr),
    .wr_ns (cp_ns),
    .wdata (sctl_wdata),
    .rd_ns (rd_ns),
    .q     (sctl_q),
    .q_sec ()
  );

  // Copy picked by the requesting world (rd_ns), used for the live enables in both worlds
  assign sctl_ns_q = sctl_q;

  // ***************************************************
  // State of this module
  // ***************************************************

  typedef struct packed {
    logic [31:0] rdata;     // Registered read data
    logic        done;      // Completion pulse
    logic        undef;     // Undefined instruction pulse
    logic        unclaimed; // Not ours pulse
    logic        so_bit;    // Secure-only control bit
    logic        nmfi_m;    // Strap synchroniser, first stage
    logic        nmfi_s;    // Strap synchroniser, second stage
    logic        world_ns;  // Security state of the last access
  } cfi_state_t;

  cfi_state_t st_reg;
  cfi_state_t st_next;

  // ***************************************************
  // Read value helpers
  // ***************************************************

  // Cache size word for the cache that the select bit picks
  function automatic logic [31:0] csize_word(input logic instr_not_data_select);
    logic [3:0] flags;
    flags = instr_not_data_select ? CSZ_FLAGS_I : CSZ_FLAGS_D;
    csize_word = '0;
    csize_word[CSZ_FLAG_POS +: 4]  = flags;
    csize_word[CSZ_SETS_POS +: 15] = CSZ_SETS;
    csize_word[CSZ_WAYS_POS +: 10] = CSZ_WAYS;
    csize_word[2:0]                = CSZ_LINE;
  endfunction

  // Control word readback: fixed ones, strap, secure-only, banked bits
  function automatic logic [31:0] sctl_word(
    input logic [3:0] bank,
    input logic       so,
    input logic       nmfi
  );
    sctl_word = SCTL_RAO_MASK;
    sctl_word[SCTL_M_POS]    = bank[0];
    sctl_word[SCTL_C_POS]    = bank[1];
    sctl_word[SCTL_Z_POS]    = bank[2];
    sctl_word[SCTL_I_POS]    = bank[3];
    sctl_word[SCTL_SO_POS]   = so;
    sctl_word[SCTL_NMFI_POS] = nmfi;
  endfunction

  // ***************************************************
  // Access qualification
  // ***************************************************

  logic claimed;
  logic user_fault;
  logic sdis_fault;
  logic fault;
  logic do_write;

  // Reads pick the copy of the requesting world
  assign rd_ns = cp_ns;

  // Every register here refuses user mode outright
  assign claimed    = (dec_bus.sel != CFI_SEL_NONE);
  assign user_fault = claimed && !cp_priv;
  // Secure control writes are blocked while the disable input is high
  assign sdis_fault = (dec_bus.sel == CFI_SEL_SCTL) && cp_write && cp_priv
                      && !cp_ns && sec_wr_disable;
  assign fault      = user_fault || sdis_fault;
  assign do_write   = cp_valid && cp_write && claimed && !fault;

  // Only two registers hold writable state; others drop the data
  assign csel_wr    = do_write && (dec_bus.sel == CFI_SEL_CSEL);
  assign sctl_wr    = do_write && (dec_bus.sel == CFI_SEL_SCTL);

  // Banked enable bits gathered from the write word
  assign sctl_wdata = {cp_wdata[SCTL_I_POS], cp_wdata[SCTL_Z_POS],
                       cp_wdata[SCTL_C_POS], cp_wdata[SCTL_M_POS]};

  // ***************************************************
  // Next state
  // ***************************************************

  // One cycle per access; pulses fall back on the following cycle
  always_comb
  begin
    st_next           = st_reg;
    st_next.done      = 1'b0;
    st_next.undef     = 1'b0;
    st_next.unclaimed = 1'b0;
    // Strap is a pin: two stages before anything reads it
    st_next.nmfi_m    = nmfi_pin;
    st_next.nmfi_s    = st_reg.nmfi_m;

    if (cp_valid)
    begin
      st_next.world_ns = cp_ns;
      if (!claimed)
      begin
        // Left for whichever bank owns these coordinates
        st_next.unclaimed = 1'b1;
        st_next.rdata     = '0;
      end
      else if (fault)
      begin
        // Faulting access returns nothing and changes nothing
        st_next.undef = 1'b1;
        st_next.rdata = '0;
      end
      else
      begin
        st_next.done = 1'b1;
        if (cp_write)
        begin
          // Write data is never echoed back
          st_next.rdata = '0;
          // Secure-only bit moves only for secure writers
          if (dec_bus.sel == CFI_SEL_SCTL && !cp_ns)
            st_next.so_bit = cp_wdata[SCTL_SO_POS];
        end
        else
        begin
          unique case (dec_bus.sel)
            CFI_SEL_FEAT2: st_next.rdata = FEAT2_VAL;
            CFI_SEL_FEAT3: st_next.rdata = FEAT3_VAL;
            CFI_SEL_FEAT4: st_next.rdata = FEAT4_VAL;
            CFI_SEL_RSVD:  st_next.rdata = RSVD_VAL;
            CFI_SEL_CSIZE: st_next.rdata = csize_word(csel_q);
            CFI_SEL_CLVL:  st_next.rdata = CLVL_VAL;
            CFI_SEL_AUX:   st_next.rdata = AUX_VAL;
            // Level bits and upper bits always read zero
            CFI_SEL_CSEL:  st_next.rdata = {31'h0, csel_q};
            CFI_SEL_SCTL:  st_next.rdata = sctl_word(sctl_q, st_reg.so_bit,
                                                     st_reg.nmfi_s);
            default:       st_next.rdata = '0;
          endcase
        end
      end
    end
  end

  // ***************************************************
  // State register
  // ***************************************************

  // Everything clears to zero, so all enables start off
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_reg <= '{rdata: 32'h0, done: 1'b0, undef: 1'b0, unclaimed: 1'b0,
                  so_bit: SCTL_SO_RST, nmfi_m: 1'b0, nmfi_s: 1'b0,
                  world_ns: 1'b0};
    end
    else
      st_reg <= st_next;
  end

  // ***************************************************
  // Outputs
  // ***************************************************

  assign cp_rdata     = st_reg.rdata;
  assign cp_done      = st_reg.done;
  assign cp_undef     = st_reg.undef;
  assign cp_unclaimed = st_reg.unclaimed;

  // Live enables follow the world of the requester's current state
  assign mmu_enable       = sctl_ns_q[0];
  assign dcache_enable    = sctl_ns_q[1];
  assign flow_pred_enable = sctl_ns_q[2];
  assign icache_enable    = sctl_ns_q[3];

  // Which cache the size word currently describes
  assign icache_selected  = csel_q;

endmodule

// ### verilog/cfi_pkg.sv
// Constants, types and field layouts of the identification and selection bank.
// Assumes one core clock, and requests from core logic on that same clock.
package cfi_pkg;

  // ***************************************************
  // Register coordinates (first opcode, crn, crm, second opcode)
  // ***************************************************
  localparam logic [2:0] OPC1_FEAT  = 3'h0;
  localparam logic [2:0] OPC1_CACHE = 3'h1;
  localparam logic [2:0] OPC1_CSEL  = 3'h2;
  localparam logic [3:0] CRN_ID     = 4'h0;
  localparam logic [3:0] CRN_CTRL   = 4'h1;
  localparam logic [3:0] CRM_ZERO   = 4'h0;
  localparam logic [3:0] CRM_FEAT   = 4'h2;
  localparam logic [2:0] OPC2_FEAT2 = 3'h2;
  localparam logic [2:0] OPC2_FEAT3 = 3'h3;
  localparam logic [2:0] OPC2_FEAT4 = 3'h4;
  localparam logic [2:0] OPC2_CSIZE = 3'h0;
  localparam logic [2:0] OPC2_CLVL  = 3'h1;
  localparam logic [2:0] OPC2_AUX   = 3'h7;
  localparam logic [2:0] OPC2_CSEL  = 3'h0;
  localparam logic [2:0] OPC2_SCTL  = 3'h0;

  // ***************************************************
  // Fixed identification words
  // ***************************************************
  localparam logic [31:0] FEAT2_VAL = 32'h2123_2041;
  localparam logic [31:0] FEAT3_VAL = 32'h1111_2131;
  localparam logic [31:0] FEAT4_VAL = 32'h0001_1000;
  localparam logic [31:0] CLVL_VAL  = 32'h0900_0003;
  localparam logic [31:0] AUX_VAL   = 32'h0000_0000;
  localparam logic [31:0] RSVD_VAL  = 32'h0000_0000;

  // ***************************************************
  // Cache size word fields
  // ***************************************************
  localparam int          CSZ_FLAG_POS  = 28;
  localparam int          CSZ_SETS_POS  = 13;
  localparam int          CSZ_WAYS_POS  = 3;
  localparam logic [3:0]  CSZ_FLAGS_I   = 4'h2;
  localparam logic [3:0]  CSZ_FLAGS_D   = 4'h7;
  localparam logic [14:0] CSZ_SETS_16K  = 15'h007f;
  localparam logic [14:0] CSZ_SETS_32K  = 15'h00ff;
  localparam logic [14:0] CSZ_SETS_64K  = 15'h01ff;
  localparam logic [14:0] CSZ_SETS      = CSZ_SETS_32K;
  localparam logic [9:0]  CSZ_WAYS      = 10'h003;
  localparam logic [2:0]  CSZ_LINE      = 3'h1;

  // ***************************************************
  // Cache select and control word fields
  // ***************************************************
  localparam int          CSEL_IND_POS  = 0;
  localparam logic        CSEL_RST      = 1'b0;
  localparam int          SCTL_M_POS    = 0;
  localparam int          SCTL_C_POS    = 2;
  localparam int          SCTL_SO_POS   = 10;
  localparam int          SCTL_Z_POS    = 11;
  localparam int          SCTL_I_POS    = 12;
  localparam int          SCTL_NMFI_POS = 27;
  localparam logic [3:0]  SCTL_BANK_RST = 4'h0;
  localparam logic        SCTL_SO_RST   = 1'b0;
  localparam logic [31:0] SCTL_RAO_MASK = 32'h00c5_0078;

  // Decoded register selection
  typedef enum logic [3:0] {
    CFI_SEL_NONE,
    CFI_SEL_FEAT2,
    CFI_SEL_FEAT3,
    CFI_SEL_FEAT4,
    CFI_SEL_RSVD,
    CFI_SEL_CSIZE,
    CFI_SEL_CLVL,
    CFI_SEL_AUX,
    CFI_SEL_CSEL,
    CFI_SEL_SCTL
  } cfi_sel_t;

endpackage

// ### verilog/cfi_dec_if.sv
// Carries the instruction coordinates to the decoder and the selection back.
// Assumes the core module drives the fields and reads the selection.
interface cfi_dec_if;
  logic [2:0]        opc1;
  logic [3:0]        crn;
  logic [3:0]        crm;
  logic [2:0]        opc2;
  cfi_pkg::cfi_sel_t sel;

  modport dec  (input opc1, input crn, input crm, input opc2, output sel);
  modport core (output opc1, output crn, output crm, output opc2, input sel);
endinterface

// ### verilog/cfi_decode.sv
// Maps coprocessor instruction coordinates onto one register of the bank.
// Assumes the coprocessor number was already matched upstream.
module cfi_decode
  import cfi_pkg::*;
(
  cfi_dec_if.dec dec // Coordinates in, selection out
);

  // ***************************************************
  // Coordinate decode
  // ***************************************************
  // Unknown coordinates fall to NONE so another bank may claim them
  always_comb
  begin
    dec.sel = CFI_SEL_NONE;
    if (dec.opc1 == OPC1_FEAT && dec.crn == CRN_ID && dec.crm == CRM_FEAT)
    begin
      unique case (dec.opc2)
        OPC2_FEAT2: dec.sel = CFI_SEL_FEAT2;
        OPC2_FEAT3: dec.sel = CFI_SEL_FEAT3;
        OPC2_FEAT4: dec.sel = CFI_SEL_FEAT4;
        3'h5, 3'h6, 3'h7: dec.sel = CFI_SEL_RSVD;
        default: dec.sel = CFI_SEL_NONE; // Lower words live elsewhere
      endcase
    end
    else if (dec.opc1 == OPC1_CACHE && dec.crn == CRN_ID && dec.crm == CRM_ZERO)
    begin
      if (dec.opc2 == OPC2_CSIZE)
        dec.sel = CFI_SEL_CSIZE;
      else if (dec.opc2 == OPC2_CLVL)
        dec.sel = CFI_SEL_CLVL;
      else if (dec.opc2 == OPC2_AUX)
        dec.sel = CFI_SEL_AUX;
    end
    else if (dec.opc1 == OPC1_CSEL && dec.crn == CRN_ID && dec.crm == CRM_ZERO
             && dec.opc2 == OPC2_CSEL)
      dec.sel = CFI_SEL_CSEL;
    else if (dec.opc1 == OPC1_FEAT && dec.crn == CRN_CTRL && dec.crm == CRM_ZERO
             && dec.opc2 == OPC2_SCTL)
      dec.sel = CFI_SEL_SCTL;
  end

endmodule

// ### verilog/cfi_bank_reg.sv
// One register field held as a secure copy and a non-secure copy.
// Assumes the caller has already checked privilege and security rights.
module cfi_bank_reg
  import cfi_pkg::*;
#(
  parameter int              W   = 1,   // Field width
  parameter logic [W-1:0]    RST = '0   // Reset value of both copies
)
(
  input  wire logic          mclk,      // Core clock
  input  wire logic          reset,     // Asynchronous reset, high
  input  wire logic          wr_en,     // Write strobe
  input  wire logic          wr_ns,     // Write targets non-secure copy
  input  wire logic [W-1:0]  wdata,     // Write data
  input  wire logic          rd_ns,     // Read the non-secure copy
  output logic      [W-1:0]  q,         // Copy chosen by rd_ns
  output logic      [W-1:0]  q_sec      // Secure copy
);

  typedef struct packed {
    logic [W-1:0] s;
    logic [W-1:0] ns;
  } cfi_bank_t;

  cfi_bank_t st_reg;
  cfi_bank_t st_next;

  // Next state: only the addressed copy changes
  always_comb
  begin
    st_next = st_reg;
    if (wr_en && wr_ns)
      st_next.ns = wdata;
    else if (wr_en)
      st_next.s = wdata;
  end

  // State register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      st_reg <= '{s: RST, ns: RST};
    else
      st_reg <= st_next;
  end

  // Read selection
  assign q     = rd_ns ? st_reg.ns : st_reg.s;
  assign q_sec = st_reg.s;

endmodule

// ### bench/cfi_id_bank_checker.sv
// Concurrent checks on the ports of the identification and selection bank.
// Assumes it is bound to cfi_id_bank and that everything runs on mclk.
module cfi_id_bank_checker
(
  input wire logic        mclk,            // Core clock
  input wire logic        reset,           // Asynchronous reset, high
  input wire logic        cp_valid,        // Request strobe
  input wire logic        cp_write,        // Write request
  input wire logic [2:0]  cp_opc1,         // First opcode
  input wire logic [3:0]  cp_crn,          // Primary register
  input wire logic [3:0]  cp_crm,          // Secondary register
  input wire logic [2:0]  cp_opc2,         // Second opcode
  input wire logic [31:0] cp_wdata,        // Write data
  input wire logic        cp_priv,         // Privileged requester
  input wire logic        cp_ns,           // Non-secure requester
  input wire logic        sec_wr_disable,  // Secure write block
  input wire logic [31:0] cp_rdata,        // Read data
  input wire logic        cp_done,         // Completed
  input wire logic        cp_undef,        // Undefined instruction
  input wire logic        cp_unclaimed,    // Not in this bank
  input wire logic        mmu_enable,      // Translation on
  input wire logic        icache_selected  // Select picks instr cache
);
  timeunit 1ns;
  timeprecision 1ns;

  // ***************************************************
  // Coordinate decode helpers
  // ***************************************************
  logic cache_hit;
  logic feat_hit;
  logic sel_hit;
  logic ctrl_hit;
  logic rd_ok;
  logic wbit0;

  // Recomputed here so a wrong decode in the design shows up
  assign cache_hit = cp_opc1 == 3'h1 && cp_crn == 4'h0 && cp_crm == 4'h0;
  assign feat_hit  = cp_opc1 == 3'h0 && cp_crn == 4'h0 && cp_crm == 4'h2;
  assign sel_hit   = cp_opc1 == 3'h2 && cp_crn == 4'h0 && cp_crm == 4'h0 && cp_opc2 == 3'h0;
  assign ctrl_hit  = cp_opc1 == 3'h0 && cp_crn == 4'h1 && cp_crm == 4'h0 && cp_opc2 == 3'h0;
  assign rd_ok     = cp_valid && cp_priv && !cp_write;
  assign wbit0     = cp_wdata[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ***************************************************
  // Assertions
  // ***************************************************
  a_one_answer: assert property (cp_valid |=> $onehot({cp_done, cp_undef, cp_unclaimed}))
    else $error("not exactly one answer to a request");
  a_user_undef: assert property (cp_valid && !cp_priv && (sel_hit || ctrl_hit
      || (cache_hit && cp_opc2 inside {3'h0, 3'h1, 3'h7}) || (feat_hit && cp_opc2 inside {[3'h2:3'h4]}))
      |=> cp_undef && !cp_done)
    else $error("user access not refused");
  a_size_word: assert property (rd_ok && cache_hit && cp_opc2 == 3'h0 |=> cp_done
      && cp_rdata == {($past(icache_selected) ? 4'h2 : 4'h7), 28'h01fe019})
    else $error("cache size word wrong");
  a_level_word: assert property (rd_ok && cache_hit && cp_opc2 == 3'h1 |=> cp_done
      && cp_rdata[29:0] == 30'h09000003)
    else $error("cache level word wrong");
  a_aux_zero: assert property (rd_ok && cache_hit && cp_opc2 == 3'h7 |=> cp_done && cp_rdata == 32'h0)
    else $error("auxiliary word not zero");
  a_feat_words: assert property (rd_ok && feat_hit && cp_opc2 inside {[3'h2:3'h4]} |=> cp_done
      && cp_rdata[31:12] == ($past(cp_opc2) == 3'h2 ? 20'h21232 :
      ($past(cp_opc2) == 3'h3 ? 20'h11112 : 20'h00011)))
    else $error("feature word wrong");
  a_ro_write: assert property (cp_valid && cp_priv && cp_write && ((feat_hit && cp_opc2 inside {[3'h2:3'h4]})
      || (cache_hit && cp_opc2 inside {3'h0, 3'h1, 3'h7})) |=> cp_done && cp_rdata == 32'h0)
    else $error("write to read-only word misbehaved");
  a_select_write: assert property (cp_valid && cp_priv && cp_write && sel_hit ##1 cp_ns == $past(cp_ns)
      |-> icache_selected == $past(wbit0))
    else $error("cache select not updated");
  a_user_hold: assert property (cp_valid && !cp_priv && sel_hit ##1 cp_ns == $past(cp_ns)
      |-> $stable(icache_selected))
    else $error("user write changed cache select");
  a_ctrl_write: assert property (cp_valid && cp_priv && cp_write && ctrl_hit && !cp_ns && !sec_wr_disable
      ##1 !cp_ns |-> mmu_enable == $past(wbit0))
    else $error("translation enable not written");
endmodule

bind cfi_id_bank cfi_id_bank_checker chk (.mclk, .reset, .cp_valid, .cp_write, .cp_opc1, .cp_crn,
  .cp_crm, .cp_opc2, .cp_wdata, .cp_priv, .cp_ns, .sec_wr_disable, .cp_rdata, .cp_done,
  .cp_undef, .cp_unclaimed, .mmu_enable, .icache_selected);

// ### bench/test_cfi_id_bank.sv
// Self-checking bench for the identification and selection bank.
// Assumes the checker is bound separately; drives all inputs at falling edges.
module test_cfi_id_bank;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk, reset, cp_valid, cp_write, cp_priv, cp_ns, sec_wr_disable, nmfi_pin;
  logic [2:0]  cp_opc1, cp_opc2;
  logic [3:0]  cp_crn, cp_crm;
  logic [31:0] cp_wdata, cp_rdata, got;
  logic        cp_done, cp_undef, cp_unclaimed, mmu_enable, dcache_enable;
  logic        flow_pred_enable, icache_enable, icache_selected;
  logic [2:0]  resp;
  int          err_total, tests_run;
  localparam logic [2:0] DONE = 3'b100, UNDEF = 3'b010, UNCL = 3'b001;
  localparam logic [31:0] FW [8] = '{0, 0, 32'h21232041, 32'h11112131, 32'h00011000, 0, 0, 0};
  // Coordinates packed as {opc1, crn, crm, opc2}
  localparam logic [13:0] COORD [6] = '{14'h0012, 14'h0800, 14'h0801, 14'h0807, 14'h1000, 14'h0080};

  cfi_id_bank uut (.mclk(mclk), .reset(reset), .cp_valid(cp_valid), .cp_write(cp_write),
    .cp_opc1(cp_opc1), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2),
    .cp_wdata(cp_wdata), .cp_priv(cp_priv), .cp_ns(cp_ns), .sec_wr_disable(sec_wr_disable),
    .nmfi_pin(nmfi_pin), .cp_rdata(cp_rdata), .cp_done(cp_done), .cp_undef(cp_undef),
    .cp_unclaimed(cp_unclaimed), .mmu_enable(mmu_enable), .dcache_enable(dcache_enable),
    .flow_pred_enable(flow_pred_enable), .icache_enable(icache_enable),
    .icache_selected(icache_selected));

  // ****************************************
  // Access and compare tasks
  // ****************************************
  // One request held over one rising edge; answer read at the next falling edge
  task automatic acc(input logic wr, input logic [13:0] c, input logic [31:0] wd,
                     input logic pv, input logic ns);
    @(negedge mclk);
    {cp_write, cp_opc1, cp_crn, cp_crm, cp_opc2} = {wr, c};
    {cp_wdata, cp_priv, cp_ns} = {wd, pv, ns};
    cp_valid = 1'b1;
    @(negedge mclk);
    cp_valid = 1'b0;
    got = cp_rdata;
    resp = {cp_done, cp_undef, cp_unclaimed};
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_resp(input logic [2:0] e);
    tests_run++;
    if (resp !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t answer %b expected %b", $time, resp, e);
    end
  endtask

  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Enables and select come out of reset cleared
  task automatic t_reset;
    chk_word({mmu_enable, dcache_enable, flow_pred_enable, icache_enable}, 0);
    chk_word(icache_selected, 0);
  endtask

  // Every feature slot from both worlds; slots 0 and 1 live elsewhere
  task automatic t_feat;
    for (int i = 0; i < 16; i++)
    begin
      acc(0, {11'h002, 3'(i)}, 0, 1, i[3]);
      chk_resp(i[2:0] < 2 ? UNCL : DONE);
      if (i[2:0] > 1) chk_word(got, FW[i[2:0]]);
    end
  endtask

  // Size, level and auxiliary words with the select at data cache
  task automatic t_cache;
    for (int n = 0; n < 2; n++)
    begin
      acc(0, COORD[1], 0, 1, n[0]);
      chk_word(got, 32'h701fe019);
      acc(0, COORD[2], 0, 1, n[0]);
      chk_word({2'b00, got[29:0]}, 32'h09000003);
      acc(0, COORD[3], 0, 1, n[0]);
      chk_word(got, 0);
    end
  endtask

  // Level bits of a write are dropped; each world keeps its own select
  task automatic t_select;
    acc(1, COORD[4], 32'hf, 1, 0);
    chk_resp(DONE);
    chk_word(icache_selected, 1);
    acc(0, COORD[4], 0, 1, 0);
    chk_word(got[3:0], 4'h1);
    acc(0, COORD[1], 0, 1, 0);
    chk_word(got, 32'h201fe019);
    acc(0, COORD[1], 0, 1, 1);
    chk_word(got, 32'h701fe019);
    chk_word(icache_selected, 0);
    acc(1, COORD[4], 32'h1, 1, 1);
    acc(1, COORD[4], 32'h0, 1, 0);
    chk_word(icache_selected, 0);
  endtask

  // User mode is refused on the six registers in COORD, reads and writes, both worlds
  task automatic t_user;
    for (int j = 0; j < 24; j++)
    begin
      acc(j[0], COORD[j >> 2], {31'h0, !j[1]}, 0, j[1]);
      chk_resp(UNDEF);
    end
    chk_word(icache_selected, 1);
    acc(0, COORD[4], 0, 1, 0);
    chk_word({got[0], mmu_enable}, 0);
  endtask

  // Writes to read-only words complete but leave the words alone
  task automatic t_ro;
    for (int k = 0; k < 3; k++)
    begin
      acc(1, COORD[k], 32'hffffffff, 1, 0);
      chk_resp(DONE);
      chk_word(got, 0);
    end
    acc(0, COORD[0], 0, 1, 0);
    chk_word(got, 32'h21232041);
  endtask

  // Banked enables, the secure-only bit and the secure write block
  task automatic t_ctrl;
    nmfi_pin = 1'b1;
    acc(1, COORD[5], 32'h1805, 1, 0);
    chk_word({mmu_enable, dcache_enable, flow_pred_enable, icache_enable}, 4'hf);
    // Full readback: fixed ones, strap now synchronised, banked enables
    acc(0, COORD[5], 0, 1, 0);
    chk_word(got, 32'h08c5187d);
    acc(0, COORD[5], 0, 1, 1);
    chk_word(got & 32'h1805, 0);
    chk_word({mmu_enable, dcache_enable, flow_pred_enable, icache_enable}, 0);
    acc(1, COORD[5], 32'h400, 1, 1);
    chk_resp(DONE);
    acc(0, COORD[5], 0, 1, 0);
    chk_word(got[10], 0);
    acc(1, COORD[5], 32'h1c05, 1, 0);
    acc(0, COORD[5], 0, 1, 1);
    chk_word(got[10], 1);
    sec_wr_disable = 1'b1;
    acc(1, COORD[5], 32'h0, 1, 0);
    chk_resp(UNDEF);
    chk_word(mmu_enable, 1);
    sec_wr_disable = 1'b0;
  endtask

  // ****************************************
  // Clock, main sequence and watchdog
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    {reset, cp_valid, cp_write, cp_priv, cp_ns, sec_wr_disable, nmfi_pin} = 7'b1000000;
    {cp_opc1, cp_crn, cp_crm, cp_opc2, cp_wdata} = '0;
    err_total = 0;
    tests_run = 0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    t_reset();
    t_feat();
    t_cache();
    t_select();
    t_user();
    t_ro();
    t_ctrl();
    print_verdict();
  end

  // About 65 accesses of two cycles each; far more than enough
  initial
  begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule
